// ==== ir_cfg_pkg.sv ====
// constants shared by the infrared transceiver configuration block
package ir_cfg_pkg;
    // register offsets
    localparam logic [2:0] OFS_CIR_CFG = 3'h2;
    localparam logic [2:0] OFS_LINK_CTRL = 3'h3;
    localparam logic [2:0] OFS_XCVR_CFG_1 = 3'h4;
    localparam logic [2:0] OFS_XCVR_CFG_2 = 3'h5;
    localparam logic [2:0] OFS_XCVR_CFG_3 = 3'h6;
    localparam logic [2:0] OFS_XCVR_CFG_4 = 3'h7;
    // consumer-ir configuration fields
    localparam int TX_HSC_POS = 2;
    localparam int RX_DEMOD_DIS_POS = 4;
    localparam int RX_HSC_POS = 5;
    localparam int RX_SAMPLING_POS = 6;
    localparam int RUN_LENGTH_POS = 7;
    localparam logic [7:0] CIR_CFG_MASK = 8'hf7;
    // transceiver configuration 1 fields
    localparam int XCVR_CTRL0_POS = 0;
    localparam int XCVR_CTRL21_LO = 1;
    localparam int IDENT3_POS = 3;
    localparam int SIR_CFG_LO = 4;
    localparam int SPECIAL_PULSE_POS = 7;
    // transceiver configuration 2 and 3 fields
    localparam int LOW_FIELD_LO = 0;
    localparam int HIGH_FIELD_LO = 4;
    localparam logic [7:0] CFG_23_MASK = 8'h77;
    // transceiver configuration 4 fields
    localparam int SEL21_DIR_POS = 3;
    localparam int RX_INVERT_POS = 4;
    localparam int SEL0_DIR_POS = 5;
    localparam int RX_INPUT_MODE_POS = 6;
    localparam int AUTO_CFG_POS = 7;
    localparam logic [7:0] CFG_4_MASK = 8'hf8;
    // reset values
    localparam logic [7:0] CIR_CFG_RESET = 8'h00;
    localparam logic [7:0] LINK_CTRL_RESET = 8'h00;
    localparam logic [7:0] XCVR_CFG_1_RESET = 8'h00;
    localparam logic [7:0] XCVR_CFG_2_RESET = 8'h00;
    localparam logic [7:0] XCVR_CFG_3_RESET = 8'h00;
    localparam logic [7:0] XCVR_CFG_4_RESET = 8'h00;
    // special transceiver pulse timing
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int SPECIAL_PULSE_US = 64;
    localparam int SPECIAL_PULSE_CYCLES = (SPECIAL_PULSE_US * CLK_FREQ_KHZ) / 1000;
    localparam int PULSE_CNT_W = 10;
    // active infrared mode reported by the link control logic
    typedef enum logic [2:0] {
        MODE_SIR,
        MODE_MIR,
        MODE_FIR,
        MODE_ASK,
        MODE_CIR,
        MODE_IDLE
    } ir_mode_e;
endpackage

// ==== ir_transceiver_config.sv ====
// infrared transceiver configuration registers, select pins, pulse timer, receive path
`timescale 1ns/100ps
module ir_transceiver_config #(
    parameter int ADDR_W = 3
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // bank 0 view of the link control location
    input wire logic link_ctrl_bank0_wr_in,
    input wire logic [7:0] link_ctrl_bank0_data_in,
    output logic [7:0] link_ctrl_out,
    // link state from the controller
    input wire logic [2:0] ir_mode_in,
    input wire logic aux_receive_select_in,
    input wire logic modulator_tx_in,
    // configuration to modulator and demodulator
    output logic tx_subcarrier_high_sel_out,
    output logic rx_demod_disable_out,
    output logic rx_carrier_high_sel_out,
    output logic rx_sampling_mode_out,
    output logic run_length_enable_out,
    output logic [1:0] tx_mod_mode_out,
    // transceiver pins
    input wire logic id0_select0_rx2_pin_in,
    output logic id0_select0_rx2_pin_out,
    output logic id0_select0_rx2_pin_oe_out,
    input wire logic [1:0] select_pins_2_1_in,
    output logic [1:0] select_pins_2_1_out,
    output logic [1:0] select_pins_2_1_oe_out,
    input wire logic third_ident_pin_in,
    input wire logic first_receive_pin_in,
    output logic ir_transmit_out,
    // selected receive data to the receiver
    output logic rx_data_out
);
    localparam int PULSE_CNT_W = ir_cfg_pkg::PULSE_CNT_W;
    localparam logic [PULSE_CNT_W-1:0] PULSE_LAST =
        PULSE_CNT_W'(ir_cfg_pkg::SPECIAL_PULSE_CYCLES - 1);

    // refuse an address too narrow for the map, or a pulse count the counter cannot hold
    if (ADDR_W < 3) begin
        $error("ADDR_W must be at least 3");
    end
    if (ir_cfg_pkg::SPECIAL_PULSE_CYCLES > 2 ** PULSE_CNT_W) begin
        $error("pulse count too large for its counter");
    end

    logic [7:0] cir_cfg_reg;
    logic [7:0] link_ctrl_reg;
    logic [2:0] xcvr_ctrl_reg;
    logic [2:0] sir_cfg_reg;
    logic [7:0] cfg2_reg;
    logic [7:0] cfg3_reg;
    logic [7:0] cfg4_reg;
    logic pulse_reg;
    logic pulse_next;
    logic [PULSE_CNT_W-1:0] pulse_cnt_reg;
    logic [2:0] sel_drive;
    logic rx_pick;
    logic hit;
    logic [2:0] ofs;
    logic pulse_start;
    ir_cfg_pkg::ir_mode_e mode;

    // shift keeps the decode legal when the address has no bits above the map
    assign hit = ((reg_addr_in >> 3) == '0);
    assign ofs = reg_addr_in[2:0];
    assign mode = ir_cfg_pkg::ir_mode_e'(ir_mode_in);

    wire logic wr_cir = reg_wr_in && hit && ofs == ir_cfg_pkg::OFS_CIR_CFG;
    wire logic wr_link = reg_wr_in && hit && ofs == ir_cfg_pkg::OFS_LINK_CTRL;
    wire logic wr_c1 = reg_wr_in && hit && ofs == ir_cfg_pkg::OFS_XCVR_CFG_1;
    wire logic wr_c2 = reg_wr_in && hit && ofs == ir_cfg_pkg::OFS_XCVR_CFG_2;
    wire logic wr_c3 = reg_wr_in && hit && ofs == ir_cfg_pkg::OFS_XCVR_CFG_3;
    wire logic wr_c4 = reg_wr_in && hit && ofs == ir_cfg_pkg::OFS_XCVR_CFG_4;
    wire logic auto_cfg = cfg4_reg[ir_cfg_pkg::AUTO_CFG_POS];
    wire logic sel0_dir = cfg4_reg[ir_cfg_pkg::SEL0_DIR_POS];
    wire logic sel21_dir = cfg4_reg[ir_cfg_pkg::SEL21_DIR_POS];
    wire logic rx_hsc = cir_cfg_reg[ir_cfg_pkg::RX_HSC_POS];

    // consumer-ir configuration; reserved bit 3 reads zero
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cir_cfg_reg <= ir_cfg_pkg::CIR_CFG_RESET;
        end else if (wr_cir) begin
            cir_cfg_reg <= reg_wdata_in & ir_cfg_pkg::CIR_CFG_MASK;
        end
    end

    // one storage for both bank views, so either write is seen by both, save a bank 0 write in the same cycle as a register write
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_ctrl_reg <= ir_cfg_pkg::LINK_CTRL_RESET;
        end else if (wr_link) begin
            link_ctrl_reg <= reg_wdata_in;
        end else if (link_ctrl_bank0_wr_in) begin
            link_ctrl_reg <= link_ctrl_bank0_data_in;
        end
    end

    // control bits only take writes while their pins are outputs
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xcvr_ctrl_reg <= ir_cfg_pkg::XCVR_CFG_1_RESET[2:0];
            sir_cfg_reg <= ir_cfg_pkg::XCVR_CFG_1_RESET[6:4];
        end else if (wr_c1) begin
            if (sel0_dir) begin
                xcvr_ctrl_reg[0] <= reg_wdata_in[ir_cfg_pkg::XCVR_CTRL0_POS];
            end
            if (sel21_dir) begin
                xcvr_ctrl_reg[2:1] <= reg_wdata_in[ir_cfg_pkg::XCVR_CTRL21_LO +: 2];
            end
            sir_cfg_reg <= reg_wdata_in[ir_cfg_pkg::SIR_CFG_LO +: 3];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg2_reg <= ir_cfg_pkg::XCVR_CFG_2_RESET;
            cfg3_reg <= ir_cfg_pkg::XCVR_CFG_3_RESET;
            cfg4_reg <= ir_cfg_pkg::XCVR_CFG_4_RESET;
        end else begin
            if (wr_c2) begin
                cfg2_reg <= reg_wdata_in & ir_cfg_pkg::CFG_23_MASK;
            end
            if (wr_c3) begin
                cfg3_reg <= reg_wdata_in & ir_cfg_pkg::CFG_23_MASK;
            end
            if (wr_c4) begin
                cfg4_reg <= reg_wdata_in & ir_cfg_pkg::CFG_4_MASK;
            end
        end
    end

    // special transceiver pulse: a write of 1 restarts even at the timeout edge
    assign pulse_start = wr_c1 && reg_wdata_in[ir_cfg_pkg::SPECIAL_PULSE_POS];

    always_comb begin
        if (pulse_start) begin
            pulse_next = 1'b1;
        end else if (pulse_reg && pulse_cnt_reg == PULSE_LAST) begin
            pulse_next = 1'b0;
        end else begin
            pulse_next = pulse_reg;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_reg <= 1'b0;
            pulse_cnt_reg <= '0;
        end else begin
            pulse_reg <= pulse_next;
            if (pulse_start) begin
                pulse_cnt_reg <= '0;
            end else if (pulse_reg) begin
                pulse_cnt_reg <= pulse_cnt_reg + PULSE_CNT_W'(1);
            end
        end
    end

    // the led is held high by the pulse; otherwise the modulator drives it
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ir_transmit_out <= 1'b0;
        end else begin
            ir_transmit_out <= pulse_next | modulator_tx_in;
        end
    end

    // select pin value per active mode
    always_comb begin
        sel_drive = xcvr_ctrl_reg;
        if (auto_cfg) begin
            case (mode)
                ir_cfg_pkg::MODE_SIR: sel_drive = sir_cfg_reg;
                ir_cfg_pkg::MODE_MIR: sel_drive = cfg2_reg[ir_cfg_pkg::LOW_FIELD_LO +: 3];
                ir_cfg_pkg::MODE_FIR: sel_drive = cfg2_reg[ir_cfg_pkg::HIGH_FIELD_LO +: 3];
                ir_cfg_pkg::MODE_CIR: begin
                    if (rx_hsc) begin
                        sel_drive = cfg3_reg[ir_cfg_pkg::HIGH_FIELD_LO +: 3];
                    end else begin
                        sel_drive = cfg3_reg[ir_cfg_pkg::LOW_FIELD_LO +: 3];
                    end
                end
                default: sel_drive = xcvr_ctrl_reg;
            endcase
        end
    end

    // directions come straight from config 4; an input pin is never driven
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            id0_select0_rx2_pin_out <= 1'b0;
            id0_select0_rx2_pin_oe_out <= 1'b0;
            select_pins_2_1_out <= 2'h0;
            select_pins_2_1_oe_out <= 2'h0;
        end else begin
            id0_select0_rx2_pin_out <= sel_drive[0];
            id0_select0_rx2_pin_oe_out <= sel0_dir;
            select_pins_2_1_out <= sel_drive[2:1];
            select_pins_2_1_oe_out <= {2{sel21_dir}};
        end
    end

    // receive input choice; pin 0 used as output gives a constant idle 1
    wire logic use_second = cfg4_reg[ir_cfg_pkg::RX_INPUT_MODE_POS] ?
        (mode == ir_cfg_pkg::MODE_MIR || mode == ir_cfg_pkg::MODE_FIR) :
        aux_receive_select_in;
    assign rx_pick = use_second ? (sel0_dir | id0_select0_rx2_pin_in) :
        first_receive_pin_in;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_data_out <= 1'b1;
        end else begin
            rx_data_out <= rx_pick ^ cfg4_reg[ir_cfg_pkg::RX_INVERT_POS];
        end
    end

    // configuration outputs to modulator and demodulator, plus the link control copy on link_ctrl_out
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_subcarrier_high_sel_out <= 1'b0;
            rx_demod_disable_out <= 1'b0;
            rx_carrier_high_sel_out <= 1'b0;
            rx_sampling_mode_out <= 1'b0;
            run_length_enable_out <= 1'b0;
            tx_mod_mode_out <= 2'h0;
            link_ctrl_out <= ir_cfg_pkg::LINK_CTRL_RESET;
        end else begin
            tx_subcarrier_high_sel_out <= cir_cfg_reg[ir_cfg_pkg::TX_HSC_POS];
            rx_demod_disable_out <= cir_cfg_reg[ir_cfg_pkg::RX_DEMOD_DIS_POS];
            rx_carrier_high_sel_out <= rx_hsc;
            rx_sampling_mode_out <= cir_cfg_reg[ir_cfg_pkg::RX_SAMPLING_POS];
            run_length_enable_out <= cir_cfg_reg[ir_cfg_pkg::RUN_LENGTH_POS];
            tx_mod_mode_out <= cir_cfg_reg[1:0];
            link_ctrl_out <= link_ctrl_reg;
        end
    end

    // read data, one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in && hit) begin
            case (ofs)
                ir_cfg_pkg::OFS_CIR_CFG: reg_rdata_out <= cir_cfg_reg;
                ir_cfg_pkg::OFS_LINK_CTRL: reg_rdata_out <= link_ctrl_reg;
                ir_cfg_pkg::OFS_XCVR_CFG_1: reg_rdata_out <= {pulse_reg, sir_cfg_reg,
                    third_ident_pin_in,
                    sel21_dir ? xcvr_ctrl_reg[2:1] : select_pins_2_1_in,
                    sel0_dir ? xcvr_ctrl_reg[0] : id0_select0_rx2_pin_in};
                ir_cfg_pkg::OFS_XCVR_CFG_2: reg_rdata_out <= cfg2_reg;
                ir_cfg_pkg::OFS_XCVR_CFG_3: reg_rdata_out <= cfg3_reg;
                ir_cfg_pkg::OFS_XCVR_CFG_4: reg_rdata_out <= cfg4_reg;
                default: reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // checks
    logic [PULSE_CNT_W:0] tx_high_run_reg;
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_high_run_reg <= '0;
        end else if (pulse_start) begin
            tx_high_run_reg <= '0;
        end else if (pulse_reg) begin
            tx_high_run_reg <= tx_high_run_reg + (PULSE_CNT_W+1)'(1);
        end
    end

    AST_PULSE_NOT_BEYOND: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        pulse_reg |-> tx_high_run_reg < (PULSE_CNT_W+1)'(ir_cfg_pkg::SPECIAL_PULSE_CYCLES))
        else $error("special pulse lasted beyond its time");
    AST_PULSE_ENDS: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (pulse_reg && pulse_cnt_reg == PULSE_LAST && !pulse_start) |=> !pulse_reg)
        else $error("special pulse did not end at timeout");
    AST_PULSE_TX_HIGH: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        pulse_start |=> (ir_transmit_out && pulse_reg && pulse_cnt_reg == '0))
        else $error("transmit not forced high after pulse write");
    AST_PULSE_ZERO_IGNORED: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_c1 && !reg_wdata_in[7] && !pulse_reg) |=> !pulse_reg)
        else $error("writing zero started a pulse");
    AST_IDENT3_LIVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (reg_rd_in && hit && ofs == ir_cfg_pkg::OFS_XCVR_CFG_1) |=>
        reg_rdata_out[3] == $past(third_ident_pin_in))
        else $error("identification bit 3 not the live pin");
    AST_CTRL0_INPUT_HELD: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (wr_c1 && !sel0_dir) |=> $stable(xcvr_ctrl_reg[0]))
        else $error("control bit 0 took a write while input");
    AST_MIR_DRIVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (auto_cfg && mode == ir_cfg_pkg::MODE_MIR && $stable(cfg2_reg)) |=>
        select_pins_2_1_out == $past(cfg2_reg[2:1]))
        else $error("mir field not on select pins");
    AST_MANUAL_DRIVE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !auto_cfg |=> id0_select0_rx2_pin_out == $past(xcvr_ctrl_reg[0]))
        else $error("manual control bit 0 not on pin");
    AST_RX_INVERT: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (cfg4_reg[4] && !use_second) |=> rx_data_out == !$past(first_receive_pin_in))
        else $error("receive input not inverted");
    AST_RX_CONST_ONE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        (use_second && sel0_dir && !cfg4_reg[4]) |=> rx_data_out)
        else $error("second receive choice not constant one");
    AST_DIR_OE: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> (id0_select0_rx2_pin_oe_out == $past(sel0_dir)
        && select_pins_2_1_oe_out == {2{$past(sel21_dir)}}))
        else $error("pin enables do not follow direction bits");

    COV_PULSE_DONE: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        pulse_reg ##1 !pulse_reg);
    COV_PULSE_RESTART: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        pulse_reg && pulse_start);
    COV_CIR_HIGH: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        auto_cfg && mode == ir_cfg_pkg::MODE_CIR && rx_hsc);
    COV_SECOND_RX: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        use_second && !sel0_dir);
endmodule

// ==== ir_xcvr_model.sv ====
// behavioural model of the optical transceiver module on the select and receive pins
`timescale 1ns/100ps
module ir_xcvr_model #(
    // identification code, value is arbitrary
    parameter logic [3:0] ID_CODE = 4'ha
) (
    // host side of the shared pins
    input wire logic [2:0] host_oe_in,
    // receive traffic from the tb
    input wire logic rx_phase_in,
    input wire logic rx1_level_in,
    input wire logic rx2_level_in,
    // module side of the pins
    output logic [2:0] sel_drv_out,
    output logic [2:0] sel_en_out,
    output logic ident3_out,
    output logic rx1_out
);
    always_comb begin
        // back off wherever the host drives, otherwise the pins would fight
        sel_en_out = ~host_oe_in;
        sel_drv_out = ID_CODE[2:0];
        // in a receive phase the shared pin 0 carries the second receive signal
        if (rx_phase_in) begin
            sel_drv_out[0] = rx2_level_in;
        end
        ident3_out = ID_CODE[3];
        rx1_out = rx1_level_in;
    end
endmodule

// ==== tb_ir_transceiver_config.sv ====
// self-checking bench for the infrared transceiver configuration block
`timescale 1ns/100ps
module tb_ir_transceiver_config;
    // identification code, value is arbitrary
    localparam logic [3:0] ID_CODE = 4'ha;
    logic ref_clk_in, rst_n_in, reg_wr_in, reg_rd_in, lc_wr, aux_in, mod_tx;
    logic [2:0] reg_addr_in, mode_in, m_drv, m_en, host_oe, host_out, pin_lvl;
    logic [7:0] reg_wdata_in, reg_rdata_out, lc_data, lc_out;
    logic tx_sub, demod, rx_carrier_high_sel, samp, rlen, id0_out, id0_oe, ir_tx, rx_data;
    logic m_id3, m_rx1, rx_phase, rx1_lvl, rx2_lvl;
    logic [1:0] modm, sel21_out, sel21_oe;
    int err_count = 0;
    int samples_checked = 0;
    // rx table: md, dir0, inv, aux, mode, expected
    logic [7:0] rx_tab[8] = '{8'b0000_000_0, 8'b0001_000_1, 8'b1000_001_1, 8'b1001_000_0,
                              8'b0101_000_1, 8'b1100_010_1, 8'b1010_000_1, 8'b0011_000_0};
    // pin table: mode, receive carrier high, expected pins
    logic [6:0] pin_tab[7] = '{7'b000_0_001, 7'b001_0_010, 7'b010_0_011, 7'b011_0_111,
                               7'b100_0_100, 7'b100_1_101, 7'b101_0_111};
    // register table: offset, written, read back
    logic [18:0] reg_tab[7] = '{{3'h2, 8'hff, 8'hf7}, {3'h3, 8'hff, 8'hff}, {3'h5, 8'hff, 8'h77},
        {3'h6, 8'hff, 8'h77}, {3'h7, 8'hff, 8'hf8}, {3'h0, 8'hff, 8'h00}, {3'h1, 8'hff, 8'h00}};

    assign host_oe = {sel21_oe, id0_oe};
    assign host_out = {sel21_out, id0_out};
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_lvl[i] = host_oe[i] ? host_out[i] : (m_en[i] ? m_drv[i] : 1'b1);
        end
    end

    ir_transceiver_config uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .link_ctrl_bank0_wr_in(lc_wr),
        .link_ctrl_bank0_data_in(lc_data), .link_ctrl_out(lc_out), .ir_mode_in(mode_in),
        .aux_receive_select_in(aux_in), .modulator_tx_in(mod_tx),
        .tx_subcarrier_high_sel_out(tx_sub), .rx_demod_disable_out(demod),
        .rx_carrier_high_sel_out(rx_carrier_high_sel), .rx_sampling_mode_out(samp),
        .run_length_enable_out(rlen), .tx_mod_mode_out(modm),
        .id0_select0_rx2_pin_in(pin_lvl[0]), .id0_select0_rx2_pin_out(id0_out),
        .id0_select0_rx2_pin_oe_out(id0_oe), .select_pins_2_1_in(pin_lvl[2:1]),
        .select_pins_2_1_out(sel21_out), .select_pins_2_1_oe_out(sel21_oe),
        .third_ident_pin_in(m_id3), .first_receive_pin_in(m_rx1), .ir_transmit_out(ir_tx),
        .rx_data_out(rx_data));

    ir_xcvr_model #(.ID_CODE(ID_CODE)) xcvr (.host_oe_in(host_oe), .rx_phase_in(rx_phase),
        .rx1_level_in(rx1_lvl), .rx2_level_in(rx2_lvl), .sel_drv_out(m_drv),
        .sel_en_out(m_en), .ident3_out(m_id3), .rx1_out(m_rx1));

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_sig(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so they are sampled there
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp, input string name);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk_reg(name, exp, reg_rdata_out);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        err_count++;
        $display("ERROR watchdog expected end of tests seen timeout");
        end_of_test();
    end

    initial begin
        {reg_wr_in, reg_rd_in, lc_wr, aux_in, mod_tx, rx_phase, rx1_lvl, rx2_lvl} = 8'h00;
        {reg_addr_in, mode_in, reg_wdata_in, lc_data} = 22'h0;
        rst_n_in = 1'b0;
        repeat (10) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        foreach (reg_tab[i]) begin
            rd_reg(reg_tab[i][18:16], 8'h00, "reset value");
            wr_reg(reg_tab[i][18:16], reg_tab[i][15:8]);
            rd_reg(reg_tab[i][18:16], reg_tab[i][7:0], "readback");
        end
        cyc(1);
        chk_reg("idle read data", 8'h00, reg_rdata_out);
        chk_sig("cir outputs", 8'h7f, {1'b0, tx_sub, demod, rx_carrier_high_sel, samp, rlen, modm});
        wr_reg(3'h2, 8'h50);
        cyc(2);
        chk_sig("cir outputs", 8'h28, {1'b0, tx_sub, demod, rx_carrier_high_sel, samp, rlen, modm});
        wr_reg(3'h2, 8'h84);
        cyc(2);
        chk_sig("cir outputs", 8'h44, {1'b0, tx_sub, demod, rx_carrier_high_sel, samp, rlen, modm});
        chk_sig("link control", 8'hff, lc_out);
        @(posedge ref_clk_in);
        lc_wr <= 1'b1;
        lc_data <= 8'h3c;
        @(posedge ref_clk_in);
        lc_wr <= 1'b0;
        cyc(2);
        chk_sig("link control", 8'h3c, lc_out);
        rd_reg(3'h3, 8'h3c, "link control read");
        $display("test registers done");
        wr_reg(3'h7, 8'h00);
        wr_reg(3'h4, 8'h07);
        rd_reg(3'h4, {4'h0, ID_CODE}, "identification read");
        chk_sig("pin enables", 8'h00, {5'h0, host_oe});
        rx_phase <= 1'b1;
        rx2_lvl <= 1'b1;
        foreach (rx_tab[i]) begin
            wr_reg(3'h7, {1'b0, rx_tab[i][7:5], 4'h0});
            aux_in <= rx_tab[i][4];
            mode_in <= rx_tab[i][3:1];
            cyc(3);
            chk_sig("receive data", {7'h0, rx_tab[i][0]}, {7'h0, rx_data});
        end
        rx_phase <= 1'b0;
        $display("test receive path done");
        wr_reg(3'h7, 8'h28);
        wr_reg(3'h4, 8'h17);
        cyc(2);
        chk_sig("pin enables", 8'h07, {5'h0, host_oe});
        chk_sig("select pins", 8'h07, {5'h0, host_out});
        rd_reg(3'h4, {4'h1, ID_CODE[3], 3'b111}, "config 1 read");
        wr_reg(3'h5, 8'h32);
        wr_reg(3'h6, 8'h54);
        wr_reg(3'h7, 8'ha8);
        foreach (pin_tab[i]) begin
            wr_reg(3'h2, {2'b00, pin_tab[i][3], 5'h00});
            mode_in <= pin_tab[i][6:4];
            cyc(3);
            chk_sig("select pins", {5'h0, pin_tab[i][2:0]}, {5'h0, host_out});
        end
        $display("test select pins done");
        wr_reg(3'h7, 8'h28);
        wr_reg(3'h4, 8'h97);
        cyc(1);
        chk_sig("transmit output", 8'h01, {7'h0, ir_tx});
        wr_reg(3'h4, 8'h17);
        cyc(636);
        chk_sig("transmit output", 8'h01, {7'h0, ir_tx});
        cyc(2);
        chk_sig("transmit output", 8'h00, {7'h0, ir_tx});
        rd_reg(3'h4, {4'h1, ID_CODE[3], 3'b111}, "pulse bit cleared");
        wr_reg(3'h4, 8'h97);
        cyc(300);
        // one rewrite only, for the restart check; no further ones, to spare the led
        wr_reg(3'h4, 8'h97);
        cyc(639);
        chk_sig("transmit output", 8'h01, {7'h0, ir_tx});
        cyc(1);
        chk_sig("transmit output", 8'h00, {7'h0, ir_tx});
        mod_tx <= 1'b1;
        cyc(2);
        chk_sig("modulator on transmit", 8'h01, {7'h0, ir_tx});
        mod_tx <= 1'b0;
        cyc(2);
        chk_sig("modulator on transmit", 8'h00, {7'h0, ir_tx});
        $display("test transmit pulse done");
        end_of_test();
    end
endmodule
